// ===== inc/vdiom_pkg.sv
// Constants, register map and carrier types of the virtual digital I/O mapper.
// Assumes a 100 MHz system clock and a single AHB-Lite master on the register bus.
// Contract
// - Duplicate nonzero virtual input functions raise warning
// - Source select 1 takes virtual level instead
// - Eight virtual input levels, reset 0, immediate
// - Full variant eight inputs, compact variant four
// - Polarity select; change valid after 3 ms (the mapper applies a polarity write on the next clock, without the filter)
// - Compact variant lacks virtual inputs 5 to 8
// - Four virtual output levels, reset 0, immediate
// - Functions 145 to 148 route virtual outputs
// - Duplicate output functions except 128 raise warning
package vdiom_pkg;

	// ==========================================================
	// Sizes
	localparam int          NUM_CH         = 8;
	localparam int          NUM_CH_COMPACT = 4;
	localparam int          NUM_VOUT       = 4;
	localparam int          NUM_DO         = 4;

	// ==========================================================
	// Timing
	localparam int          CLK_MHZ        = 100;
	localparam int          FILTER_TIME_US = 3000;
	localparam int          FILTER_CYCLES  = FILTER_TIME_US * CLK_MHZ;

	// ==========================================================
	// Register byte addresses (low byte of the bus address)
	localparam logic [7:0]  ADDR_VIN_LEVEL   = 8'h00;
	localparam logic [7:0]  ADDR_SRC_SEL     = 8'h04;
	localparam logic [7:0]  ADDR_POLARITY    = 8'h08;
	localparam logic [7:0]  ADDR_VOUT_LEVEL  = 8'h0C;
	localparam logic [7:0]  ADDR_VIN_FUNC_LO = 8'h10;
	localparam logic [7:0]  ADDR_VIN_FUNC_HI = 8'h14;
	localparam logic [7:0]  ADDR_DO_FUNC     = 8'h18;
	localparam logic [7:0]  ADDR_STATE       = 8'h20;
	localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h24;
	localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h28;

	// ==========================================================
	// Field positions
	localparam int          STATE_HW_POS   = 8;
	localparam int          STATE_IDUP_POS = 16;
	localparam int          STATE_ODUP_POS = 17;
	localparam int          STATE_DO_POS   = 20;
	localparam int          IRQ_IDUP_BIT   = 0;
	localparam int          IRQ_ODUP_BIT   = 1;
	localparam int          IRQ_CHG_BIT    = 2;
	localparam int          IRQ_W          = 3;

	// ==========================================================
	// Function numbers and reset values
	localparam logic [7:0]  FUNC_IN_NONE   = 8'h00;
	localparam logic [7:0]  FUNC_OUT_NONE  = 8'h80;
	localparam logic [7:0]  FUNC_VDO_FIRST = 8'h91;
	localparam logic [7:0]  FUNC_VDO_LAST  = 8'h94;
	localparam logic [7:0]  RST_CH_BITS    = 8'h00;
	localparam logic [3:0]  RST_VOUT       = 4'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ   = 3'h0;
	localparam logic [7:0]  MASK_COMPACT   = 8'h0F;
	localparam logic [7:0]  MASK_FULL      = 8'hFF;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} vdiom_phase_t;

	typedef struct packed {
		logic in_dup;
		logic out_dup;
	} vdiom_warn_t;

endpackage

// ===== rtl/vdiom_in_filter.sv
// One hardware input channel: synchroniser and persistence qualifier.
// Assumes the pin is asynchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module vdiom_in_filter #(
	parameter int P_CYCLES = vdiom_pkg::FILTER_CYCLES
) (
	input  wire logic i_clock,
	input  wire logic i_nrst,
	input  wire logic i_pin,
	output var  logic o_level
);

	localparam int CW = $clog2(P_CYCLES + 1);

	logic          sync_a;
	logic          sync_b;
	logic [CW-1:0] count;

	// ==========================================================
	// Synchroniser; only sync_b is looked at
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			sync_a <= i_pin;
			sync_b <= sync_a;
		end
	end

	// ==========================================================
	// Accept a new level once it has differed for P_CYCLES+1 samples,
	// so a change must last strictly longer than the filter time
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			count   <= '0;
			o_level <= 1'b0;
		end else if (sync_b == o_level) begin
			count <= '0; // Glitch shorter than the window is dropped
		end else if (count == CW'(P_CYCLES)) begin
			o_level <= sync_b;
			count   <= '0;
		end else begin
			count <= count + CW'(1);
		end
	end

endmodule
`default_nettype wire

// ===== rtl/vdiom_mapper.sv
// Virtual digital input/output mapper with AHB-Lite register slave.
// Assumes one AHB-Lite master, word transfers, and asynchronous input pins.
`timescale 1ns/1ps
`default_nettype none
module vdiom_mapper #(
	parameter int P_FILTER_CYCLES = vdiom_pkg::FILTER_CYCLES,
	parameter bit P_COMPACT       = 1'b0
) (
	input  wire logic        I_CLOCK,
	input  wire logic        I_NRST,
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output var  logic        O_HREADYOUT,
	output var  logic [31:0] O_HRDATA,
	output var  logic        O_HRESP,
	input  wire logic [7:0]  I_DI_PIN,
	input  wire logic [3:0]  I_DO_DRIVE,
	output var  logic [7:0]  O_DI_LEVEL,
	output var  logic [3:0]  O_DO_PIN,
	output var  logic        O_IN_DUP_WARN,
	output var  logic        O_OUT_DUP_WARN,
	output var  logic        O_IRQ
);

	// ==========================================================
	// Helpers

	// Any two enabled entries with equal function other than skip
	function automatic logic dup_found(input logic [7:0][7:0] func,
	                                   input logic [7:0]      en,
	                                   input logic [7:0]      skip);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			for (int j = i + 1; j < 8; j++) begin
				if (en[i] && en[j] && func[i] == func[j] && func[i] != skip) begin
					hit = 1'b1;
				end
			end
		end
		return hit;
	endfunction

	// Channels that exist in this variant
	localparam logic [7:0] CH_MASK = P_COMPACT ? vdiom_pkg::MASK_COMPACT : vdiom_pkg::MASK_FULL;

	// ==========================================================
	// Declarations
	vdiom_pkg::vdiom_phase_t         dphase;
	logic                            rd_wait;
	logic [7:0]                      rd_addr;
	logic [7:0]                      vin_level;
	logic [7:0]                      src_sel;
	logic [7:0]                      polarity;
	logic [3:0]                      vout_level;
	logic [7:0][7:0]                 vin_func;
	logic [3:0][7:0]                 do_func;
	logic [vdiom_pkg::IRQ_W-1:0]     irq_status;
	logic [vdiom_pkg::IRQ_W-1:0]     irq_mask;
	logic [7:0]                      hw_level;
	logic [7:0]                      next_di_level;
	logic [3:0]                      next_do_pin;
	vdiom_pkg::vdiom_warn_t          next_warn;
	vdiom_pkg::vdiom_warn_t          warn;
	logic [vdiom_pkg::IRQ_W-1:0]     irq_event;
	logic                            addr_take;
	logic                            wr_en;
	logic [31:0]                     wdata;
	logic [7:0]                      waddr;

	// ==========================================================
	// Hardware input channels
	genvar g;
	generate
		for (g = 0; g < vdiom_pkg::NUM_CH; g++) begin : gen_ch
			if (CH_MASK[g]) begin : gen_hw
				vdiom_in_filter #(
					.P_CYCLES (P_FILTER_CYCLES)
				) u_filter (
					.i_clock  (I_CLOCK),
					.i_nrst   (I_NRST),
					.i_pin    (I_DI_PIN[g]),
					.o_level  (hw_level[g])
				);
			end else begin : gen_absent
				assign hw_level[g] = 1'b0;
			end
		end
	endgenerate

	// ==========================================================
	// AHB-Lite address and data phase tracking
	assign addr_take = I_HSEL && I_HTRANS[1] && I_HREADY;
	assign wr_en     = dphase.valid && dphase.write;
	assign wdata     = I_HWDATA;
	assign waddr     = dphase.addr;

	// Capture the address phase; writes complete without wait states
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			dphase <= '0;
		end else if (addr_take) begin
			dphase.valid <= 1'b1;
			dphase.write <= I_HWRITE;
			dphase.addr  <= {I_HADDR[7:2], 2'b00};
		end else if (O_HREADYOUT) begin
			dphase <= '0;
		end
	end

	// Reads insert one wait state so a write just before is visible
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			rd_wait     <= 1'b0;
			rd_addr     <= 8'h00;
			O_HREADYOUT <= 1'b1;
		end else if (addr_take && !I_HWRITE) begin
			rd_wait     <= 1'b1;
			rd_addr     <= {I_HADDR[7:2], 2'b00};
			O_HREADYOUT <= 1'b0;
		end else begin
			rd_wait     <= 1'b0;
			O_HREADYOUT <= 1'b1;
		end
	end

	// Response is always OKAY
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_HRESP <= 1'b0;
		end else begin
			O_HRESP <= 1'b0;
		end
	end

	// ==========================================================
	// Read data; unmapped and absent fields read as zero
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_HRDATA <= 32'h0000_0000;
		end else if (rd_wait) begin
			O_HRDATA <= 32'h0000_0000;
			unique case (rd_addr)
				vdiom_pkg::ADDR_VIN_LEVEL:   O_HRDATA[7:0] <= vin_level;
				vdiom_pkg::ADDR_SRC_SEL:     O_HRDATA[7:0] <= src_sel;
				vdiom_pkg::ADDR_POLARITY:    O_HRDATA[7:0] <= polarity;
				vdiom_pkg::ADDR_VOUT_LEVEL:  O_HRDATA[3:0] <= vout_level;
				vdiom_pkg::ADDR_VIN_FUNC_LO: O_HRDATA <= {vin_func[3], vin_func[2], vin_func[1], vin_func[0]};
				vdiom_pkg::ADDR_VIN_FUNC_HI: O_HRDATA <= {vin_func[7], vin_func[6], vin_func[5], vin_func[4]};
				vdiom_pkg::ADDR_DO_FUNC:     O_HRDATA <= {do_func[3], do_func[2], do_func[1], do_func[0]};
				vdiom_pkg::ADDR_STATE: begin
					O_HRDATA[7:0] <= O_DI_LEVEL;
					O_HRDATA[vdiom_pkg::STATE_HW_POS +: 8] <= hw_level;
					O_HRDATA[vdiom_pkg::STATE_IDUP_POS] <= warn.in_dup;
					O_HRDATA[vdiom_pkg::STATE_ODUP_POS] <= warn.out_dup;
					O_HRDATA[vdiom_pkg::STATE_DO_POS +: 4] <= O_DO_PIN;
				end
				vdiom_pkg::ADDR_IRQ_STATUS:  O_HRDATA[vdiom_pkg::IRQ_W-1:0] <= irq_status;
				vdiom_pkg::ADDR_IRQ_MASK:    O_HRDATA[vdiom_pkg::IRQ_W-1:0] <= irq_mask;
				default:                     O_HRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// ==========================================================
	// Virtual input levels; absent channels stay zero
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			vin_level <= vdiom_pkg::RST_CH_BITS;
		end else if (wr_en && waddr == vdiom_pkg::ADDR_VIN_LEVEL) begin
			vin_level <= wdata[7:0] & CH_MASK;
		end
	end

	// Channel source and polarity selection
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			src_sel  <= vdiom_pkg::RST_CH_BITS;
			polarity <= vdiom_pkg::RST_CH_BITS;
		end else if (wr_en) begin
			if (waddr == vdiom_pkg::ADDR_SRC_SEL) begin
				src_sel <= wdata[7:0] & CH_MASK;
			end
			if (waddr == vdiom_pkg::ADDR_POLARITY) begin
				polarity <= wdata[7:0] & CH_MASK;
			end
		end
	end

	// Virtual output levels
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			vout_level <= vdiom_pkg::RST_VOUT;
		end else if (wr_en && waddr == vdiom_pkg::ADDR_VOUT_LEVEL) begin
			vout_level <= wdata[3:0];
		end
	end

	// Function assignments; upper virtual inputs ignored on compact parts
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			vin_func <= {8{vdiom_pkg::FUNC_IN_NONE}};
			do_func  <= {4{vdiom_pkg::FUNC_OUT_NONE}};
		end else if (wr_en) begin
			if (waddr == vdiom_pkg::ADDR_VIN_FUNC_LO) begin
				vin_func[3:0] <= wdata;
			end
			if (waddr == vdiom_pkg::ADDR_VIN_FUNC_HI && !P_COMPACT) begin
				vin_func[7:4] <= wdata;
			end
			if (waddr == vdiom_pkg::ADDR_DO_FUNC) begin
				do_func <= wdata;
			end
		end
	end

	// ==========================================================
	// Channel logic: source mux, then polarity. Virtual levels skip the
	// filter because they must act at once.
	always_comb begin
		next_di_level = 8'h00;
		for (int i = 0; i < vdiom_pkg::NUM_CH; i++) begin
			if (src_sel[i]) begin
				next_di_level[i] = vin_level[i] ^ polarity[i];
			end else begin
				next_di_level[i] = hw_level[i] ^ polarity[i];
			end
		end
		next_di_level = next_di_level & CH_MASK;
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_DI_LEVEL <= 8'h00;
		end else begin
			O_DI_LEVEL <= next_di_level;
		end
	end

	// ==========================================================
	// Output routing: 145..148 pick a virtual output, others the dispatcher
	always_comb begin
		next_do_pin = 4'h0;
		for (int t = 0; t < vdiom_pkg::NUM_DO; t++) begin
			if (do_func[t] >= vdiom_pkg::FUNC_VDO_FIRST && do_func[t] <= vdiom_pkg::FUNC_VDO_LAST) begin
				next_do_pin[t] = vout_level[2'(do_func[t] - vdiom_pkg::FUNC_VDO_FIRST)];
			end else begin
				next_do_pin[t] = I_DO_DRIVE[t];
			end
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_DO_PIN <= 4'h0;
		end else begin
			O_DO_PIN <= next_do_pin;
		end
	end

	// ==========================================================
	// Duplicate warnings, recomputed every cycle from the live tables
	always_comb begin
		next_warn.in_dup  = dup_found(vin_func, CH_MASK, vdiom_pkg::FUNC_IN_NONE);
		next_warn.out_dup = dup_found({32'h0000_0000, do_func}, 8'h0F, vdiom_pkg::FUNC_OUT_NONE);
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			warn <= '0;
		end else begin
			warn <= next_warn;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_IN_DUP_WARN  <= 1'b0;
			O_OUT_DUP_WARN <= 1'b0;
		end else begin
			O_IN_DUP_WARN  <= next_warn.in_dup;
			O_OUT_DUP_WARN <= next_warn.out_dup;
		end
	end

	// ==========================================================
	// Interrupts: rising warnings and any channel change are events
	always_comb begin
		irq_event = '0;
		irq_event[vdiom_pkg::IRQ_IDUP_BIT] = next_warn.in_dup && !warn.in_dup;
		irq_event[vdiom_pkg::IRQ_ODUP_BIT] = next_warn.out_dup && !warn.out_dup;
		irq_event[vdiom_pkg::IRQ_CHG_BIT]  = next_di_level != O_DI_LEVEL;
	end

	// Write one to clear; a new event in the same cycle wins
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_status <= vdiom_pkg::RST_IRQ;
		end else if (wr_en && waddr == vdiom_pkg::ADDR_IRQ_STATUS) begin
			irq_status <= (irq_status & ~wdata[vdiom_pkg::IRQ_W-1:0]) | irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_mask <= vdiom_pkg::RST_IRQ;
		end else if (wr_en && waddr == vdiom_pkg::ADDR_IRQ_MASK) begin
			irq_mask <= wdata[vdiom_pkg::IRQ_W-1:0];
		end
	end

	// Level output, one cycle behind the status bits
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(irq_status & irq_mask);
		end
	end

endmodule
`default_nettype wire

// ===== verif/vdiom_switches.sv
// Switches wired to the hardware input terminals.
// Assumes the bench commands a resting level and, on demand, contact chatter.
`timescale 1ns/1ps
`default_nettype none
module vdiom_switches (
	input  wire logic       i_clock,
	input  wire logic [7:0] i_rest,
	input  wire logic [7:0] i_chatter,
	output var  logic [7:0] o_pin
);
	// ==========================================================
	// Chattering contacts flip every cycle, far shorter than the qualifier
	initial o_pin = 8'h00;
	always @(posedge i_clock) begin
		o_pin <= (i_rest & ~i_chatter) | ((o_pin ^ i_chatter) & i_chatter);
	end
endmodule
`default_nettype wire

// ===== verif/vdiom_mapper_asserts.sv
// Checker of the virtual I/O mapper, fed only by its top ports.
// Assumes one bus master and hready tied to hreadyout; keeps a shadow of bus writes.
`timescale 1ns/1ps
`default_nettype none
module vdiom_mapper_asserts #(
	parameter int P_FILTER_CYCLES = 20,
	parameter bit P_COMPACT       = 1'b0
) (
	input wire logic        I_CLOCK,
	input wire logic        I_NRST,
	input wire logic        I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0]  I_HTRANS,
	input wire logic        I_HWRITE,
	input wire logic [31:0] I_HWDATA,
	input wire logic        I_HREADY,
	input wire logic        O_HREADYOUT,
	input wire logic        O_HRESP,
	input wire logic [7:0]  I_DI_PIN,
	input wire logic [3:0]  I_DO_DRIVE,
	input wire logic [7:0]  O_DI_LEVEL,
	input wire logic [3:0]  O_DO_PIN,
	input wire logic        O_IN_DUP_WARN,
	input wire logic        O_OUT_DUP_WARN,
	input wire logic        O_IRQ
);
	localparam logic [7:0] CM  = P_COMPACT ? 8'h0F : 8'hFF;
	localparam int         NCH = P_COMPACT ? 4 : 8;
	logic [31:0] shd [16];
	logic        ph_wr;
	logic [7:0]  ph_a;
	logic [7:0]  pin_q;
	logic [7:0]  lvl_q;
	logic [7:0]  okv;
	logic [7:0]  vm;
	logic [3:0]  exp_do;
	logic        idup;
	logic        odup;
	logic [63:0] ifw;
	logic [7:0]  f;
	int          stab [8];
	int          quiet;

	// ==========================================================
	// Shadow registers, plus how long each pin and the setup stood still
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			ph_wr <= 1'b0;
			ph_a  <= 8'h00;
			pin_q <= 8'h00;
			lvl_q <= 8'h00;
			quiet <= 0;
			for (int i = 0; i < 16; i++) shd[i] <= (i == 6) ? 32'h80808080 : 32'h00000000;
			for (int c = 0; c < 8; c++) stab[c] <= 0;
		end else begin
			ph_wr <= I_HSEL & I_HTRANS[1] & I_HREADY & I_HWRITE;
			ph_a  <= I_HADDR[7:0];
			pin_q <= I_DI_PIN;
			lvl_q <= O_DI_LEVEL;
			if (ph_wr && I_HREADY) shd[ph_a[5:2]] <= I_HWDATA;
			quiet <= (ph_wr && (ph_a[5:2] == 4'h1 || ph_a[5:2] == 4'h2)) ? 0 : (quiet < 15 ? quiet + 1 : quiet);
			for (int c = 0; c < 8; c++) stab[c] <= (I_DI_PIN[c] != pin_q[c]) ? 0 : stab[c] + 1;
		end
	end

	// Expected routing and duplicate flags from the shadow
	always_comb begin
		vm   = shd[1][7:0] & CM;
		ifw  = {shd[5], shd[4]};
		idup = 1'b0;
		odup = 1'b0;
		for (int c = 0; c < 8; c++) okv[c] = stab[c] >= P_FILTER_CYCLES;
		for (int t = 0; t < 4; t++) begin
			f = shd[6][8*t+:8];
			exp_do[t] = (f >= vdiom_pkg::FUNC_VDO_FIRST && f <= vdiom_pkg::FUNC_VDO_LAST) ?
				shd[3][2'(f - vdiom_pkg::FUNC_VDO_FIRST)] : I_DO_DRIVE[t];
		end
		for (int i = 0; i < 8; i++) begin
			for (int j = i + 1; j < NCH; j++) begin
				if (ifw[8*i+:8] == ifw[8*j+:8] && ifw[8*i+:8] != vdiom_pkg::FUNC_IN_NONE) idup = 1'b1;
				if (j < 4 && shd[6][8*i+:8] == shd[6][8*j+:8] && shd[6][8*i+:8] != vdiom_pkg::FUNC_OUT_NONE) odup = 1'b1;
			end
		end
	end

	// ==========================================================
	// Properties
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_NRST);
	sequence s_take_rd; I_HSEL && I_HTRANS[1] && I_HREADY && !I_HWRITE; endsequence
	sequence s_one_wait; !O_HREADYOUT ##1 O_HREADYOUT; endsequence
	property p_read_wait; s_take_rd |=> s_one_wait; endproperty
	a_read_wait: assert property (p_read_wait) else $error("read without exactly one wait");
	property p_write_nowait; I_HSEL && I_HTRANS[1] && I_HREADY && I_HWRITE |=> O_HREADYOUT; endproperty
	a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
	property p_resp_okay; O_HRESP == 1'b0; endproperty
	a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
	property p_route; $past(I_NRST) |-> O_DO_PIN == $past(exp_do); endproperty
	a_route: assert property (p_route) else $error("output terminal level wrong");
	property p_in_dup; $past(I_NRST) |-> O_IN_DUP_WARN == $past(idup); endproperty
	a_in_dup: assert property (p_in_dup) else $error("input duplicate flag wrong");
	property p_out_dup; $past(I_NRST) |-> O_OUT_DUP_WARN == $past(odup); endproperty
	a_out_dup: assert property (p_out_dup) else $error("output duplicate flag wrong");
	property p_virt; $past(I_NRST) |-> (O_DI_LEVEL & $past(vm)) == $past((shd[0][7:0] ^ shd[2][7:0]) & vm); endproperty
	a_virt: assert property (p_virt) else $error("virtual channel level wrong");
	property p_filter; quiet > 3 |-> ((O_DI_LEVEL ^ lvl_q) & ~vm & CM & ~okv) == 8'h00; endproperty
	a_filter: assert property (p_filter) else $error("hardware level changed too early");
	property p_irq_dup; $rose(O_OUT_DUP_WARN) && shd[10][1] |=> O_IRQ; endproperty
	a_irq_dup: assert property (p_irq_dup) else $error("interrupt missing after duplicate");
endmodule

bind vdiom_mapper vdiom_mapper_asserts #(.P_FILTER_CYCLES(P_FILTER_CYCLES), .P_COMPACT(P_COMPACT)) u_chk (
	.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_HSEL(I_HSEL), .I_HADDR(I_HADDR), .I_HTRANS(I_HTRANS),
	.I_HWRITE(I_HWRITE), .I_HWDATA(I_HWDATA), .I_HREADY(I_HREADY), .O_HREADYOUT(O_HREADYOUT),
	.O_HRESP(O_HRESP), .I_DI_PIN(I_DI_PIN), .I_DO_DRIVE(I_DO_DRIVE), .O_DI_LEVEL(O_DI_LEVEL),
	.O_DO_PIN(O_DO_PIN), .O_IN_DUP_WARN(O_IN_DUP_WARN), .O_OUT_DUP_WARN(O_OUT_DUP_WARN), .O_IRQ(O_IRQ));
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench of the virtual I/O mapper: bus tasks, reference model, scenarios.
// Assumes the package, mapper, checker and switch model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int PF = 20;
	logic        clk, nrst, hsel, hwrite, ready, hresp, iw, ow, irq;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, seed, d;
	logic [7:0]  rest, chat, pin, lvl;
	logic [3:0]  do_drive, do_pin;
	int          m [16];
	int          err_count, n_tests, hwm, pid, pod;

	vdiom_mapper #(.P_FILTER_CYCLES(PF), .P_COMPACT(1'b0)) uut (
		.I_CLOCK(clk), .I_NRST(nrst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
		.I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(ready), .O_HREADYOUT(ready), .O_HRDATA(hrdata),
		.O_HRESP(hresp), .I_DI_PIN(pin), .I_DO_DRIVE(do_drive), .O_DI_LEVEL(lvl), .O_DO_PIN(do_pin),
		.O_IN_DUP_WARN(iw), .O_OUT_DUP_WARN(ow), .O_IRQ(irq));
	vdiom_switches u_sw (.i_clock(clk), .i_rest(rest), .i_chatter(chat), .o_pin(pin));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================
	// Reporting and comparison
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: read %h want %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: port %h want %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// ==========================================================
	// Bus master: bounded wait for ready, sampled at the rising edge
	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'b1 && n < 50);
		if (ready !== 1'b1) begin
			err_count++;
			$display("unexpected at %0t: bus hang", $time);
			conclude();
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] v);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= v;
		wait_rdy();
		d = hrdata;
	endtask
	// Write updates the model by access kind
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		xfer(a, 1'b1, v);
		case (a[5:2])
			4'h0, 4'h1, 4'h2: m[a[5:2]] = v & 32'hFF;
			4'h3: m[3] = v & 32'hF;
			4'h9: m[9] = m[9] & ~v;
			4'hA: m[10] = v & 32'h7;
			4'h7, 4'h8, 4'hB: ;
			default: m[a[5:2]] = v;
		endcase
	endtask
	task automatic chk_rd(input logic [7:0] a);
		xfer(a, 1'b0, 32'h00000000);
		chk_reg(d, m[a[5:2]]);
	endtask

	// Port levels against the reference model
	function automatic int fb(int w, int k);
		return (m[w + k / 4] >> (8 * (k % 4))) & 255;
	endfunction
	task automatic check_ports;
		int e;
		int id;
		int od;
		repeat (3) @(posedge clk);
		chk_pin(lvl, 8'(((m[1] & m[0]) | (~m[1] & hwm)) ^ m[2]));
		e = 0;
		for (int t = 0; t < 4; t++) begin
			id = fb(6, t);
			e |= ((id >= 145 && id <= 148) ? (m[3] >> (id - 145)) & 1 : (do_drive >> t) & 1) << t;
		end
		chk_pin({4'h0, do_pin}, 8'(e));
		id = 0;
		od = 0;
		for (int i = 0; i < 8; i++) begin
			for (int j = i + 1; j < 8; j++) begin
				id |= (fb(4, i) == fb(4, j) && fb(4, i) != 0);
				od |= (j < 4 && fb(6, i) == fb(6, j) && fb(6, i) != 128);
			end
		end
		chk_pin({6'h00, iw, ow}, 8'(2 * id + od));
		m[9] |= (id & ~pid & 1) | ((od & ~pod & 1) << 1);
		pid = id;
		pod = od;
		chk_pin({7'h00, irq}, {7'h00, |(m[9] & m[10])});
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{nrst, hsel, hwrite, htrans, haddr, hwdata, do_drive, rest, chat} = '0;
		{err_count, n_tests, hwm, pid, pod} = '0;
		seed = 32'h00000052;
		for (int i = 0; i < 16; i++) m[i] = (i == 6) ? 32'h80808080 : 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// Reset values, then random write and read back, unmapped places included
		for (int i = 0; i < 12; i++) chk_rd(8'(4 * i));
		foreach (m[i]) if (i < 12 && i != 8 && i != 9) begin
			wr(8'(4 * i), rnd());
			chk_rd(8'(4 * i));
		end
		wr(8'h28, 32'h00000000);
		check_ports();
		$display("register table done");
		// Random virtual levels, routing codes and duplicate patterns
		repeat (8) begin
			do_drive <= 4'(rnd());
			wr(8'h00, rnd());
			wr(8'h04, rnd());
			wr(8'h08, rnd());
			wr(8'h0C, rnd());
			wr(8'h10, rnd() & 32'h03030303);
			wr(8'h14, rnd() & 32'h03030303);
			d = rnd();
			for (int t = 0; t < 4; t++) d[8*t+:8] = d[8*t+2] ? 8'h80 : 8'h91 + 8'(d[8*t+:2]);
			wr(8'h18, d);
			check_ports();
		end
		$display("random mapping done");
		// Interrupt raised, masked and cleared
		wr(8'h10, 32'h04030201);
		wr(8'h14, 32'h08070605);
		wr(8'h18, 32'h80808080);
		check_ports();
		wr(8'h24, 32'h00000007);
		wr(8'h28, 32'h00000003);
		wr(8'h10, 32'h04030505);
		check_ports();
		xfer(8'h24, 1'b0, 32'h00000000);
		chk_reg(d & 32'h3, m[9] & 3);
		wr(8'h10, 32'h04030605);
		wr(8'h24, 32'h00000001);
		check_ports();
		wr(8'h28, 32'h00000000);
		wr(8'h18, 32'h80809191);
		check_ports();
		wr(8'h28, 32'h00000002);
		check_ports();
		wr(8'h24, 32'h00000002);
		check_ports();
		$display("interrupt done");
		// Hardware path: qualifier delay, chatter rejected, both polarities
		wr(8'h04, 32'h00000000);
		wr(8'h08, 32'h00000000);
		rest <= 8'(rnd()) | 8'h01;
		repeat (PF / 2 - 3) @(posedge clk);
		check_ports();
		repeat (PF) @(posedge clk);
		hwm = rest;
		check_ports();
		chat <= 8'hFF;
		repeat (PF / 2) @(posedge clk);
		chat <= 8'h00;
		check_ports();
		repeat (PF + 5) @(posedge clk);
		check_ports();
		wr(8'h08, 32'h000000FF);
		check_ports();
		// A qualified level change must have left its sticky event bit
		xfer(8'h24, 1'b0, 32'h00000000);
		chk_reg(d & 32'h4, 32'h00000004);
		$display("hardware inputs done");
		conclude();
	end
endmodule
`default_nettype wire
